// file: hw/counter_cfg.svh
// Offsets, field positions, reset values and limits of the counter block
`ifndef COUNTER_CFG_SVH
`define COUNTER_CFG_SVH

`define APB_AW 8
`define APB_DW 32

`define OFF_CTRL 8'h00
`define OFF_PRESET_DN 8'h04
`define OFF_PRESET_UD16 8'h08
`define OFF_PRESET_UD32 8'h0C
`define OFF_COUNT_DN 8'h10
`define OFF_COUNT_UD16 8'h14
`define OFF_COUNT_UD32 8'h18
`define OFF_STATUS 8'h1C
`define OFF_STEP 8'h20

`define CTRL_W 8
`define CTRL_RST 8'h00
`define CTRL_SEL_DN 0
`define CTRL_SEL_UD16 1
`define CTRL_SEL_UD32 2
`define CTRL_LOAD_DN 3
`define CTRL_LOAD_UD16 4
`define CTRL_LOAD_UD32 5
`define CTRL_CLR_UD16 6
`define CTRL_CLR_UD32 7

`define EDGE_W 5
`define EDGE_RST 5'h00
`define EDGE_DN_CD 0
`define EDGE_U16_CU 1
`define EDGE_U16_CD 2
`define EDGE_U32_CU 3
`define EDGE_U32_CD 4

`define ST_DN_LOW 0
`define ST_U16_UP 1
`define ST_U16_LOW 2
`define ST_U32_UP 3
`define ST_U32_LOW 4

`define NARROW_W 16
`define WIDE_W 32
`define COUNT_RST 32'h0000_0000
`define PRESET_RST 32'h0000_0000
`define MAX16 32'sh0000_7FFF
`define MIN16 32'shFFFF_8000
`define MAX32 32'sh7FFF_FFFF
`define MIN32 32'sh8000_0000
`define ONE32 32'sh0000_0001

`endif

// file: hw/counter_pkg.sv
// Types shared by the saturating counter block
`include "counter_cfg.svh"

package counter_pkg;

  typedef struct packed {
    logic [`APB_AW-1:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [`APB_DW-1:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [`APB_DW-1:0] prdata;
  } apb_rsp_s;

  typedef struct packed {
    logic count_down_in;
    logic load_in;
  } down_in_s;

  typedef struct packed {
    logic count_up_in;
    logic count_down_in;
    logic load_in;
    logic clear_in;
  } updown_in_s;

  typedef logic signed [`WIDE_W-1:0] wide_t;
  typedef logic signed [`NARROW_W-1:0] narrow_t;

endpackage : counter_pkg

// file: hw/saturating_updown_counter.sv
// Saturating down counter and 16/32-bit up/down counters with APB register access
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "counter_cfg.svh"

module saturating_updown_counter (
  input wire logic core_clk,
  input wire logic rst,
  input wire counter_pkg::apb_req_s apb_req,
  output counter_pkg::apb_rsp_s apb_rsp,
  input wire counter_pkg::down_in_s down_in,
  input wire counter_pkg::narrow_t down_preset_value,
  output counter_pkg::narrow_t down_count_value,
  output logic down_lower_hit,
  input wire counter_pkg::updown_in_s ud16_in,
  input wire counter_pkg::narrow_t ud16_preset_value,
  output counter_pkg::narrow_t ud16_count_value,
  output logic ud16_upper_hit,
  output logic ud16_lower_hit,
  input wire counter_pkg::updown_in_s ud32_in,
  input wire counter_pkg::wide_t ud32_preset_value,
  output counter_pkg::wide_t ud32_count_value,
  output logic ud32_upper_hit,
  output logic ud32_lower_hit
);

  // One counting step in 32-bit arithmetic; narrow counters pass sign-extended values
  function automatic counter_pkg::wide_t step_count(
    input counter_pkg::wide_t cur,
    input counter_pkg::wide_t pv,
    input counter_pkg::wide_t maxv,
    input counter_pkg::wide_t minv,
    input logic up_e,
    input logic dn_e,
    input logic load,
    input logic clr
  );
    counter_pkg::wide_t res;
    res = cur;
    if (clr) begin
      res = counter_pkg::wide_t'(`COUNT_RST);
    end else if (load) begin
      res = pv;
    end else if (up_e && dn_e) begin
      res = cur;
    end else if (up_e && (cur != maxv)) begin
      res = cur + `ONE32;
    end else if (dn_e && (cur != minv)) begin
      res = cur - `ONE32;
    end
    return res;
  endfunction : step_count

  function automatic counter_pkg::wide_t widen(input counter_pkg::narrow_t v);
    return counter_pkg::wide_t'(v);
  endfunction : widen

  function automatic logic is_mapped(input logic [`APB_AW-1:0] a);
    return (a == `OFF_CTRL) || (a == `OFF_PRESET_DN) || (a == `OFF_PRESET_UD16) ||
           (a == `OFF_PRESET_UD32) || (a == `OFF_COUNT_DN) || (a == `OFF_COUNT_UD16) ||
           (a == `OFF_COUNT_UD32) || (a == `OFF_STATUS) || (a == `OFF_STEP);
  endfunction : is_mapped

  logic [`CTRL_W-1:0] ctrl_r;
  counter_pkg::narrow_t preset_dn_r;
  counter_pkg::narrow_t preset_u16_r;
  counter_pkg::wide_t preset_u32_r;
  logic [`EDGE_W-1:0] step_r;
  logic [`EDGE_W-1:0] edge_prev_r;
  logic [`EDGE_W-1:0] level_now;
  logic [`EDGE_W-1:0] rise;
  counter_pkg::narrow_t dn_cnt_r;
  counter_pkg::narrow_t u16_cnt_r;
  counter_pkg::wide_t u32_cnt_r;
  counter_pkg::wide_t dn_cnt_nxt;
  counter_pkg::wide_t u16_cnt_nxt;
  counter_pkg::wide_t u32_cnt_nxt;
  counter_pkg::narrow_t dn_pv;
  counter_pkg::narrow_t u16_pv;
  counter_pkg::wide_t u32_pv;
  logic dn_load;
  logic u16_load;
  logic u32_load;
  logic u16_clr;
  logic u32_clr;
  logic [`EDGE_W-1:0] status;
  logic [`APB_DW-1:0] rd_mux;
  logic [`APB_DW-1:0] prdata_r;
  logic pslverr_r;
  logic setup_ph;
  logic wr_go;

  // Bus side: zero wait states, read data and error captured in the setup cycle
  assign setup_ph = apb_req.psel && !apb_req.penable;
  assign wr_go = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign apb_rsp.pready = apb_req.psel && apb_req.penable;
  assign apb_rsp.pslverr = pslverr_r;
  assign apb_rsp.prdata = prdata_r;

  // Preset source: register when its select bit is set, else the input port
  assign dn_pv = ctrl_r[`CTRL_SEL_DN] ? preset_dn_r : down_preset_value;
  assign u16_pv = ctrl_r[`CTRL_SEL_UD16] ? preset_u16_r : ud16_preset_value;
  assign u32_pv = ctrl_r[`CTRL_SEL_UD32] ? preset_u32_r : ud32_preset_value;

  // Load and clear are levels; software bits act alongside the ports
  assign dn_load = down_in.load_in || ctrl_r[`CTRL_LOAD_DN];
  assign u16_load = ud16_in.load_in || ctrl_r[`CTRL_LOAD_UD16];
  assign u32_load = ud32_in.load_in || ctrl_r[`CTRL_LOAD_UD32];
  assign u16_clr = ud16_in.clear_in || ctrl_r[`CTRL_CLR_UD16];
  assign u32_clr = ud32_in.clear_in || ctrl_r[`CTRL_CLR_UD32];

  // A software step is a one-cycle high on the count level, so it only counts
  // when the port input was low in the cycle before it
  always_comb begin
    level_now = step_r;
    level_now[`EDGE_DN_CD] = step_r[`EDGE_DN_CD] || down_in.count_down_in;
    level_now[`EDGE_U16_CU] = step_r[`EDGE_U16_CU] || ud16_in.count_up_in;
    level_now[`EDGE_U16_CD] = step_r[`EDGE_U16_CD] || ud16_in.count_down_in;
    level_now[`EDGE_U32_CU] = step_r[`EDGE_U32_CU] || ud32_in.count_up_in;
    level_now[`EDGE_U32_CD] = step_r[`EDGE_U32_CD] || ud32_in.count_down_in;
  end

  assign rise = level_now & ~edge_prev_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      edge_prev_r <= `EDGE_RST;
    end else begin
      edge_prev_r <= level_now;
    end
  end

  // Down counter is the up/down step with no up edge and no clear
  assign dn_cnt_nxt = step_count(widen(dn_cnt_r), widen(dn_pv), `MAX16, `MIN16, 1'b0,
                                 rise[`EDGE_DN_CD], dn_load, 1'b0);
  assign u16_cnt_nxt = step_count(widen(u16_cnt_r), widen(u16_pv), `MAX16, `MIN16,
                                  rise[`EDGE_U16_CU], rise[`EDGE_U16_CD], u16_load,
                                  u16_clr);
  assign u32_cnt_nxt = step_count(u32_cnt_r, u32_pv, `MAX32, `MIN32,
                                  rise[`EDGE_U32_CU], rise[`EDGE_U32_CD], u32_load,
                                  u32_clr);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dn_cnt_r <= counter_pkg::narrow_t'(`COUNT_RST);
    end else begin
      dn_cnt_r <= dn_cnt_nxt[`NARROW_W-1:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      u16_cnt_r <= counter_pkg::narrow_t'(`COUNT_RST);
    end else begin
      u16_cnt_r <= u16_cnt_nxt[`NARROW_W-1:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      u32_cnt_r <= counter_pkg::wide_t'(`COUNT_RST);
    end else begin
      u32_cnt_r <= u32_cnt_nxt;
    end
  end

  // Flags follow the count and the live preset without a register stage
  assign down_lower_hit = (dn_cnt_r <= counter_pkg::narrow_t'(`COUNT_RST));
  assign ud16_upper_hit = (u16_cnt_r >= u16_pv);
  assign ud16_lower_hit = (u16_cnt_r <= counter_pkg::narrow_t'(`COUNT_RST));
  assign ud32_upper_hit = (u32_cnt_r >= u32_pv);
  assign ud32_lower_hit = (u32_cnt_r <= counter_pkg::wide_t'(`COUNT_RST));

  assign down_count_value = dn_cnt_r;
  assign ud16_count_value = u16_cnt_r;
  assign ud32_count_value = u32_cnt_r;

  always_comb begin
    status = `EDGE_RST;
    status[`ST_DN_LOW] = down_lower_hit;
    status[`ST_U16_UP] = ud16_upper_hit;
    status[`ST_U16_LOW] = ud16_lower_hit;
    status[`ST_U32_UP] = ud32_upper_hit;
    status[`ST_U32_LOW] = ud32_lower_hit;
  end

  // Control and preset registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= `CTRL_RST;
    end else if (wr_go && (apb_req.paddr == `OFF_CTRL)) begin
      ctrl_r <= apb_req.pwdata[`CTRL_W-1:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      preset_dn_r <= counter_pkg::narrow_t'(`PRESET_RST);
    end else if (wr_go && (apb_req.paddr == `OFF_PRESET_DN)) begin
      preset_dn_r <= apb_req.pwdata[`NARROW_W-1:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      preset_u16_r <= counter_pkg::narrow_t'(`PRESET_RST);
    end else if (wr_go && (apb_req.paddr == `OFF_PRESET_UD16)) begin
      preset_u16_r <= apb_req.pwdata[`NARROW_W-1:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      preset_u32_r <= counter_pkg::wide_t'(`PRESET_RST);
    end else if (wr_go && (apb_req.paddr == `OFF_PRESET_UD32)) begin
      preset_u32_r <= apb_req.pwdata;
    end
  end

  // Step bits clear themselves the cycle after the write
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      step_r <= `EDGE_RST;
    end else if (wr_go && (apb_req.paddr == `OFF_STEP)) begin
      step_r <= apb_req.pwdata[`EDGE_W-1:0];
    end else begin
      step_r <= `EDGE_RST;
    end
  end

  // Read multiplexer; narrow values read sign-extended, step reads as zero
  always_comb begin
    rd_mux = '0;
    unique case (apb_req.paddr)
      `OFF_CTRL: rd_mux = {{(`APB_DW-`CTRL_W){1'b0}}, ctrl_r};
      `OFF_PRESET_DN: rd_mux = widen(preset_dn_r);
      `OFF_PRESET_UD16: rd_mux = widen(preset_u16_r);
      `OFF_PRESET_UD32: rd_mux = preset_u32_r;
      `OFF_COUNT_DN: rd_mux = widen(dn_cnt_r);
      `OFF_COUNT_UD16: rd_mux = widen(u16_cnt_r);
      `OFF_COUNT_UD32: rd_mux = u32_cnt_r;
      `OFF_STATUS: rd_mux = {{(`APB_DW-`EDGE_W){1'b0}}, status};
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata_r <= '0;
    end else if (setup_ph) begin
      prdata_r <= apb_req.pwrite ? '0 : rd_mux;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pslverr_r <= 1'b0;
    end else if (setup_ph) begin
      pslverr_r <= !is_mapped(apb_req.paddr);
    end
  end

endmodule : saturating_updown_counter
`default_nettype wire

// file: testbench/counter_properties.sv
// Checker of count, saturation and flag relations at the counter ports
`timescale 1ns/1ps
`default_nettype none
module counter_properties (
  input wire logic core_clk,
  input wire logic rst,
  input wire counter_pkg::down_in_s down_in,
  input wire counter_pkg::narrow_t down_preset_value,
  input wire counter_pkg::narrow_t down_count_value,
  input wire logic down_lower_hit,
  input wire counter_pkg::updown_in_s ud16_in,
  input wire counter_pkg::narrow_t ud16_preset_value,
  input wire counter_pkg::narrow_t ud16_count_value,
  input wire logic ud16_upper_hit,
  input wire counter_pkg::updown_in_s ud32_in,
  input wire counter_pkg::wide_t ud32_preset_value,
  input wire counter_pkg::wide_t ud32_count_value,
  input wire logic ud32_lower_hit
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_dn_lower_flag: assert property (
    down_lower_hit == (down_count_value <= 16'sh0000)) else $error("down flag wrong");
  a_u16_upper_flag: assert property (
    ud16_upper_hit == (ud16_count_value >= ud16_preset_value)) else $error("upper flag wrong");
  a_u32_lower_flag: assert property (
    ud32_lower_hit == (ud32_count_value <= 32'sh0000_0000)) else $error("lower flag wrong");
  a_dn_load_hold: assert property (down_in.load_in |=>
    down_count_value == $past(down_preset_value)) else $error("down load wrong");
  a_u32_load_take: assert property (ud32_in.load_in && !ud32_in.clear_in |=>
    ud32_count_value == $past(ud32_preset_value)) else $error("wide load wrong");
  a_u16_clear_zero: assert property (
    ud16_in.clear_in |=> ud16_count_value == 16'sh0000) else $error("clear wrong");
  a_dn_edge_step: assert property ($rose(down_in.count_down_in) && !down_in.load_in &&
    down_count_value != 16'sh8000 |=> down_count_value == $past(down_count_value) - 16'sh0001)
    else $error("down step wrong");
  a_dn_floor_hold: assert property (
    down_count_value == 16'sh8000 && !down_in.load_in |=> down_count_value == 16'sh8000)
    else $error("floor left");
  a_u16_both_edges: assert property ($rose(ud16_in.count_up_in) &&
    $rose(ud16_in.count_down_in) && !ud16_in.load_in && !ud16_in.clear_in |=>
    $stable(ud16_count_value)) else $error("both edges moved count");
endmodule : counter_properties
bind saturating_updown_counter counter_properties counter_properties_inst (.core_clk, .rst,
  .down_in, .down_preset_value, .down_count_value, .down_lower_hit, .ud16_in,
  .ud16_preset_value, .ud16_count_value, .ud16_upper_hit, .ud32_in, .ud32_preset_value,
  .ud32_count_value, .ud32_lower_hit);
`default_nettype wire

// file: testbench/ladder_model.sv
// Ladder logic model that turns edge requests into count levels
`timescale 1ns/1ps
`default_nettype none
module ladder_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [4:0] edge_mask,
  input wire logic [4:0] lvl,
  input wire logic slow,
  output counter_pkg::down_in_s down_in,
  output counter_pkg::updown_in_s ud16_in,
  output counter_pkg::updown_in_s ud32_in
);
  logic [4:0] act_r;
  logic hold_r;
  // Slow mode keeps a level up two cycles, which must still count once
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      act_r <= 5'h00;
      hold_r <= 1'b0;
    end else if (edge_mask != 5'h00) begin
      act_r <= edge_mask;
      hold_r <= slow;
    end else if (hold_r) begin
      hold_r <= 1'b0;
    end else begin
      act_r <= 5'h00;
    end
  end
  assign down_in = {act_r[0], lvl[0]};
  assign ud16_in = {act_r[1], act_r[2], lvl[1], lvl[2]};
  assign ud32_in = {act_r[3], act_r[4], lvl[3], lvl[4]};
endmodule : ladder_model
`default_nettype wire

// file: testbench/tb_saturating_updown_counter.sv
// Directed bench for the saturating counters and their register port
`timescale 1ns/1ps
`default_nettype none
`include "counter_cfg.svh"
module tb_saturating_updown_counter;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic slow = 1'b0;
  logic [4:0] edge_mask = 5'h00;
  logic [4:0] lvl = 5'h00;
  counter_pkg::apb_req_s apb_req = '0;
  counter_pkg::apb_rsp_s apb_rsp;
  counter_pkg::down_in_s down_in;
  counter_pkg::updown_in_s ud16_in;
  counter_pkg::updown_in_s ud32_in;
  counter_pkg::narrow_t down_preset_value = 16'sh0000;
  counter_pkg::narrow_t ud16_preset_value = 16'sh0000;
  counter_pkg::wide_t ud32_preset_value = 32'sh0000_0000;
  counter_pkg::narrow_t down_count_value;
  counter_pkg::narrow_t ud16_count_value;
  counter_pkg::wide_t ud32_count_value;
  logic down_lower_hit;
  logic ud16_upper_hit;
  logic ud16_lower_hit;
  logic ud32_upper_hit;
  logic ud32_lower_hit;
  logic [31:0] rd;
  logic err;
  int bad_count = 0;
  int total_checks = 0;
  always #2.5 core_clk = ~core_clk;
  saturating_updown_counter saturating_updown_counter_inst (.core_clk, .rst, .apb_req,
    .apb_rsp, .down_in, .down_preset_value, .down_count_value, .down_lower_hit, .ud16_in,
    .ud16_preset_value, .ud16_count_value, .ud16_upper_hit, .ud16_lower_hit, .ud32_in,
    .ud32_preset_value, .ud32_count_value, .ud32_upper_hit, .ud32_lower_hit);
  ladder_model ladder_model_inst (.core_clk, .rst, .edge_mask, .lvl, .slow, .down_in,
    .ud16_in, .ud32_in);
  task complete_run();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    apb_req.paddr <= a;
    apb_req.pwrite <= w;
    apb_req.pwdata <= d;
    apb_req.psel <= 1'b1;
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    @(posedge core_clk);
    while (apb_rsp.pready !== 1'b1) @(posedge core_clk);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  // Leaves the line low long enough for the next request to be a fresh edge
  task pulse(input logic [4:0] m);
    edge_mask <= m;
    @(posedge core_clk);
    edge_mask <= 5'h00;
    repeat (4) @(posedge core_clk);
  endtask : pulse
  task level(input logic [4:0] l);
    lvl <= l;
    repeat (3) @(posedge core_clk);
  endtask : level
  task endt(input string n);
    $display("test %s done", n);
  endtask : endt
  initial begin
    repeat (5000) @(posedge core_clk);
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    check(down_count_value, 16'sh0000);
    check(ud32_lower_hit, 1'b1);
    repeat (3) pulse(5'h01);
    slow <= 1'b1;
    pulse(5'h01);
    slow <= 1'b0;
    check(down_count_value, 16'shFFFC);
    check(down_lower_hit, 1'b1);
    down_preset_value <= 16'sh0002;
    lvl <= 5'h01;
    pulse(5'h01);
    check(down_count_value, 16'sh0002);
    level(5'h00);
    check(down_lower_hit, 1'b0);
    down_preset_value <= 16'sh8001;
    level(5'h01);
    level(5'h00);
    repeat (2) pulse(5'h01);
    check(down_count_value, 16'sh8000);
    endt("down");
    ud16_preset_value <= 16'sh7FFE;
    level(5'h02);
    level(5'h00);
    check(ud16_upper_hit, 1'b1);
    pulse(5'h04);
    check(ud16_count_value, 16'sh7FFD);
    check(ud16_upper_hit, 1'b0);
    pulse(5'h06);
    check(ud16_count_value, 16'sh7FFD);
    repeat (3) pulse(5'h02);
    check(ud16_count_value, 16'sh7FFF);
    level(5'h06);
    check(ud16_count_value, 16'sh0000);
    level(5'h00);
    pulse(5'h04);
    check(ud16_lower_hit, 1'b1);
    endt("ud16");
    ud32_preset_value <= 32'sh7FFF_FFFE;
    level(5'h08);
    level(5'h00);
    repeat (2) pulse(5'h08);
    check(ud32_count_value, 32'h7FFF_FFFF);
    ud32_preset_value <= 32'sh8000_0001;
    level(5'h08);
    level(5'h00);
    repeat (2) pulse(5'h10);
    check(ud32_count_value, 32'h8000_0000);
    check(ud32_upper_hit, 1'b0);
    level(5'h18);
    check(ud32_count_value, 32'h0000_0000);
    level(5'h00);
    endt("ud32");
    apb(1'b1, `OFF_PRESET_UD16, 32'h0000_1234);
    apb(1'b0, `OFF_PRESET_UD16, 32'h0000_0000);
    check(rd, 32'h0000_1234);
    apb(1'b0, 8'h24, 32'h0000_0000);
    check(err, 1'b1);
    apb(1'b1, `OFF_COUNT_DN, 32'h0000_0005);
    apb(1'b0, `OFF_COUNT_DN, 32'h0000_0000);
    check(rd, 32'hFFFF_8000);
    apb(1'b1, `OFF_STEP, 32'h0000_0002);
    repeat (3) @(posedge core_clk);
    check(ud16_count_value, 16'sh0000);
    // Software load bit acts as a load level until it is written back to zero
    apb(1'b1, `OFF_CTRL, 32'h0000_0010);
    apb(1'b1, `OFF_CTRL, 32'h0000_0000);
    check(ud16_count_value, 16'sh7FFE);
    check(ud16_upper_hit, 1'b1);
    endt("apb");
    complete_run();
  end
endmodule : tb_saturating_updown_counter
`default_nettype wire
